// [csc_defs.vh]
// constants for the charger status and control block
`ifndef CSC_DEFS_VH
`define CSC_DEFS_VH
// ----------------------------------------
// timing (clock 125 MHz)
// ----------------------------------------
`define CSC_CLK_MHZ          125
`define CSC_FAULT_PULSE_US   128
`define CSC_FAULT_PULSE_CYC  (`CSC_FAULT_PULSE_US * `CSC_CLK_MHZ)
`define CSC_FAULT_PULSE_W    14
`define CSC_SAFETY_MIN       27
`define CSC_SAFETY_CYC       (`CSC_SAFETY_MIN * 40'h3C * `CSC_CLK_MHZ * 40'hF4240)
`define CSC_WDOG_S           12
`define CSC_WDOG_CYC         (`CSC_WDOG_S * `CSC_CLK_MHZ * 40'hF4240)
`define CSC_TMR_W            40
// ----------------------------------------
// input limit codes
// ----------------------------------------
`define CSC_ILIM_NONE        2'h0
`define CSC_ILIM_100MA       2'h1
`define CSC_ILIM_HOST        2'h2
`define CSC_ICHG_1A          1'h1
`endif

// [csc_pulse.v]
// fixed-length fault pulse generator, not retriggerable
module csc_pulse #(
    parameter LEN = 16000,
    parameter W   = 14
) (
    // clock and reset
    input  wire clk,
    input  wire nrst,
    // trigger and pulse
    input  wire trig,
    output reg  busy_q
);
    reg [W-1:0] cnt_q;
    // ----------------------------------------
    // counter
    // ----------------------------------------
    always @(posedge clk) begin
        if (!nrst) begin
            cnt_q  <= {W{1'b0}};
            busy_q <= 1'b0;
        end else if (busy_q) begin
            // later faults ignored while busy
            if (cnt_q == LEN[W-1:0] - 1'b1) begin
                busy_q <= 1'b0;
                cnt_q  <= {W{1'b0}};
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end else if (trig) begin
            busy_q <= 1'b1;
            cnt_q  <= {W{1'b0}};
        end
    end
endmodule // csc_pulse

// [csc_top.v]
// charger status pins, disable/source inputs, accessory gate, thermistor handling
// Functional notes
// - host status pin pulled low while charging, released when done or disabled
// - charge status pin pulled low while charging, released when done or disabled
// - any fault while no pulse is running gives one 128 us low pulse on both status pins
// - status enable bit gates both status pins entirely
// - disable input high stops charging and enters high impedance mode
// - disable toggle resets safety timer only in default mode
// - default mode: source select high means usb: 100 mA input limit
// - default mode: source select low means adapter: no input limit, 1 A charge
// - accessory output connected only when its enable bit is set
// - default mode: cold or hot pack suspends charging
// - default mode: warm band reduces current; all thermistor faults reported
// - host mode: thermistor faults reported but charging unaffected
// - two operating modes, default and host
// - safety timer 27 minutes, watchdog 12 seconds
// - default mode until host communication is established
// - watchdog expiry returns to default mode if safety timer still running
`include "csc_defs.vh"
module csc_top #(
    parameter SAFETY_CYC = `CSC_SAFETY_CYC,
    parameter WDOG_CYC   = `CSC_WDOG_CYC
) (
    // clock and reset
    input  wire       CLK,
    input  wire       NRST,
    // pins from outside
    input  wire       CHARGE_DISABLE_IN,
    input  wire       SOURCE_SELECT_IN,
    // thermistor comparator results
    input  wire       PACK_TS_COLD,
    input  wire       PACK_TS_HOT,
    input  wire       PACK_TS_WARM,
    // charge engine state
    input  wire       CHARGE_ACTIVE,
    input  wire       OTHER_FAULT,
    // host serial control
    input  wire       HOST_ACCESS,
    input  wire       HOST_TMR_RST,
    input  wire       STAT_ENABLE,
    input  wire       ACC_POWER_EN,
    input  wire [1:0] HOST_ILIM,
    // status pins, open drain
    output reg        INT_STAT_O,
    output reg        INT_STAT_OE,
    output reg        CHG_STAT_O,
    output reg        CHG_STAT_OE,
    // accessory power
    output reg        ACCESSORY_POWER_OUT,
    // charge control
    output reg        CHARGE_RUN,
    output reg        HIZ_MODE,
    output reg        CHARGE_REDUCED,
    output reg [1:0]  INPUT_LIMIT,
    output reg        CHARGE_1A,
    output reg        HOST_MODE,
    output reg        SAFETY_EXPIRED,
    output reg [2:0]  TS_FAULT
);
    // ----------------------------------------
    // mode states, one hot
    // ----------------------------------------
    localparam ST_DEFAULT = 2'b01;
    localparam ST_HOST    = 2'b10;
    // timer width and end points, cut to that width on purpose
    localparam          TW          = `CSC_TMR_W;
    localparam [TW-1:0] SAFETY_LAST = SAFETY_CYC - 1'b1;
    localparam [TW-1:0] WDOG_LOAD   = WDOG_CYC;
    reg        [TW-1:0] safety_q;
    reg        [TW-1:0] wdog_q;

    reg        cd_s1_q, cd_s2_q, cd_s3_q;
    reg        ps_s1_q, ps_s2_q;
    reg [1:0]  mode_q;
    reg [1:0]  mode_d;
    reg        safety_exp_q;
    reg [2:0]  ts_prev_q;
    wire       cd_edge;
    wire       pulse_busy;
    wire       fault_evt;
    wire       in_default;
    wire       ts_stop;
    wire       charging;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // reset to the pins' idle levels so no false toggle follows reset
    always @(posedge CLK) begin
        if (!NRST) begin
            cd_s1_q <= 1'b0;
            cd_s2_q <= 1'b0;
            cd_s3_q <= 1'b0;
            ps_s1_q <= 1'b1;
            ps_s2_q <= 1'b1;
        end else begin
            cd_s1_q <= CHARGE_DISABLE_IN;
            cd_s2_q <= cd_s1_q;
            cd_s3_q <= cd_s2_q;
            ps_s1_q <= SOURCE_SELECT_IN;
            ps_s2_q <= ps_s1_q;
        end
    end
    assign cd_edge = cd_s2_q ^ cd_s3_q;

    // ----------------------------------------
    // mode machine
    // ----------------------------------------
    assign in_default = mode_q[0];
    always @* begin
        mode_d = mode_q;
        case (mode_q)
            ST_DEFAULT: begin
                if (HOST_ACCESS)
                    mode_d = ST_HOST;
            end
            ST_HOST: begin
                // a host restart in the expiry cycle keeps host mode
                if (wdog_q == {TW{1'b0}} && !safety_exp_q
                        && !HOST_ACCESS && !HOST_TMR_RST)
                    mode_d = ST_DEFAULT;
            end
            default: mode_d = ST_DEFAULT;
        endcase
    end

    // ----------------------------------------
    // safety and watchdog timers
    // ----------------------------------------
    // both timers count plain cycles: 27 min at 125 MHz needs 38 bits,
    // so the header sets one wider width for both
    always @(posedge CLK) begin
        if (!NRST) begin
            mode_q       <= ST_DEFAULT;
            safety_q     <= {TW{1'b0}};
            wdog_q       <= {TW{1'b0}};
            safety_exp_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            if (mode_q != mode_d && mode_d == ST_DEFAULT)
                safety_q <= {TW{1'b0}};
            else if (in_default && cd_edge)
                safety_q <= {TW{1'b0}};
            else if (charging && !safety_exp_q)
                safety_q <= safety_q + 1'b1;
            if (charging && safety_q == SAFETY_LAST)
                safety_exp_q <= 1'b1;
            else if (cd_s2_q)
                safety_exp_q <= 1'b0;
            if (HOST_ACCESS || HOST_TMR_RST)
                wdog_q <= WDOG_LOAD;
            else if (wdog_q != {TW{1'b0}})
                wdog_q <= wdog_q - 1'b1;
        end
    end

    // ----------------------------------------
    // thermistor, charge control
    // ----------------------------------------
    assign ts_stop  = in_default && (PACK_TS_COLD || PACK_TS_HOT);
    assign charging = CHARGE_ACTIVE && !cd_s2_q && !ts_stop && !safety_exp_q;
    // fault sources: other faults, safety expiry, any thermistor flag rising
    assign fault_evt = OTHER_FAULT || (safety_q == SAFETY_LAST && charging)
                     || (|({PACK_TS_COLD, PACK_TS_HOT, PACK_TS_WARM} & ~ts_prev_q));

    csc_pulse #(
        .LEN (`CSC_FAULT_PULSE_CYC),
        .W   (`CSC_FAULT_PULSE_W)
    ) u_pulse (
        .clk    (CLK),
        .nrst   (NRST),
        .trig   (fault_evt),
        .busy_q (pulse_busy)
    );

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always @(posedge CLK) begin
        if (!NRST) begin
            INT_STAT_O          <= 1'b0;
            INT_STAT_OE         <= 1'b0;
            CHG_STAT_O          <= 1'b0;
            CHG_STAT_OE         <= 1'b0;
            ACCESSORY_POWER_OUT <= 1'b0;
            CHARGE_RUN          <= 1'b0;
            HIZ_MODE            <= 1'b0;
            CHARGE_REDUCED      <= 1'b0;
            INPUT_LIMIT         <= `CSC_ILIM_100MA;
            CHARGE_1A           <= 1'b0;
            HOST_MODE           <= 1'b0;
            SAFETY_EXPIRED      <= 1'b0;
            TS_FAULT            <= 3'h0;
            ts_prev_q           <= 3'h0;
        end else begin
            ts_prev_q   <= {PACK_TS_COLD, PACK_TS_HOT, PACK_TS_WARM};
            // a pulse during charging merges into the low level,
            // so the host sees it only while charging is off
            INT_STAT_OE <= STAT_ENABLE && (pulse_busy || charging);
            CHG_STAT_OE <= STAT_ENABLE && (pulse_busy || charging);
            INT_STAT_O  <= 1'b0;
            CHG_STAT_O  <= 1'b0;
            ACCESSORY_POWER_OUT <= ACC_POWER_EN;
            CHARGE_RUN     <= charging;
            HIZ_MODE       <= cd_s2_q;
            CHARGE_REDUCED <= in_default && PACK_TS_WARM && !PACK_TS_HOT;
            TS_FAULT       <= {PACK_TS_COLD, PACK_TS_HOT, PACK_TS_WARM};
            HOST_MODE      <= mode_q[1];
            SAFETY_EXPIRED <= safety_exp_q;
            if (mode_q[1])
                INPUT_LIMIT <= HOST_ILIM;
            else if (ps_s2_q)
                INPUT_LIMIT <= `CSC_ILIM_100MA;
            else
                INPUT_LIMIT <= `CSC_ILIM_NONE;
            CHARGE_1A <= in_default && !ps_s2_q ? `CSC_ICHG_1A : 1'b0;
        end
    end
endmodule // csc_top

// [csc_checker.sv]
// concurrent checks on the charger status block ports
module csc_checker (
    input wire logic       CLK, NRST, CHARGE_DISABLE_IN, SOURCE_SELECT_IN, OTHER_FAULT,
    input wire logic       PACK_TS_HOT, PACK_TS_WARM, PACK_TS_COLD, STAT_ENABLE, ACC_POWER_EN,
    input wire logic       INT_STAT_O, INT_STAT_OE, CHG_STAT_O, CHG_STAT_OE, ACCESSORY_POWER_OUT,
    input wire logic       CHARGE_RUN, CHARGE_1A, HOST_MODE, CHARGE_REDUCED,
    input wire logic [1:0] INPUT_LIMIT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic [14:0] run_q;
    // length of an oe run not explained by charging
    always_ff @(posedge CLK) begin
        run_q <= (!NRST || !INT_STAT_OE || CHARGE_RUN) ? 15'h0 : run_q + 15'h1;
    end
    pins_match_a: assert property (INT_STAT_OE == CHG_STAT_OE && !INT_STAT_O && !CHG_STAT_O)
        else $error("status pins disagree");
    stat_gate_a: assert property (!STAT_ENABLE |=> !INT_STAT_OE && !CHG_STAT_OE)
        else $error("status pin active while gated");
    pulse_start_a: assert property ($rose(OTHER_FAULT) && STAT_ENABLE && !INT_STAT_OE && !CHARGE_RUN |-> ##2 INT_STAT_OE)
        else $error("fault pulse missing");
    pulse_len_a: assert property (run_q <= 15'h3E80)
        else $error("fault pulse too long");
    acc_on_a: assert property ($rose(ACC_POWER_EN) |=> ACCESSORY_POWER_OUT)
        else $error("accessory output not connected");
    hiz_stop_a: assert property (CHARGE_DISABLE_IN[*5] |-> !CHARGE_RUN)
        else $error("charging while disabled");
    usb_limit_a: assert property ((SOURCE_SELECT_IN && !HOST_MODE)[*5] |-> INPUT_LIMIT == 2'h1)
        else $error("usb limit wrong");
    adapter_limit_a: assert property ((!SOURCE_SELECT_IN && !HOST_MODE)[*5] |-> INPUT_LIMIT == 2'h0 && CHARGE_1A)
        else $error("adapter limit wrong");
    ts_suspend_a: assert property ((!HOST_MODE && (PACK_TS_HOT || PACK_TS_COLD))[*3] |-> !CHARGE_RUN)
        else $error("charging with pack too hot or cold");
    warm_reduce_a: assert property ((!HOST_MODE && PACK_TS_WARM && !PACK_TS_HOT && !PACK_TS_COLD)[*3] |-> CHARGE_REDUCED)
        else $error("warm band not reduced");
endmodule // csc_checker
bind csc_top csc_checker u_chk (.*);

// [csc_host_model.sv]
// host side of the status lines: pull-ups on both open-drain pins
module csc_host_model (
    input  wire logic int_o, int_oe, chg_o, chg_oe,
    output wire logic int_pin, chg_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // released line goes to the pull-up, never keeps the last level
    assign int_pin = int_oe ? int_o : 1'b1;
    assign chg_pin = chg_oe ? chg_o : 1'b1;
endmodule // csc_host_model

// [test_charger_status_control.sv]
// self-checking bench for the charger status block
module test_charger_status_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, nrst = 1'b0, dis = 1'b1, psel = 1'b0, hot = 1'b0, warm = 1'b0;
    logic       cold = 1'b0, ca = 1'b0, flt = 1'b0, hacc = 1'b0, hrst = 1'b0, sten = 1'b0;
    logic       acc = 1'b0;
    logic [1:0] ilim = 2'h0;
    wire        int_o, int_oe, chg_o, chg_oe, accout, run, hiz, red, c1a, hmode, sexp;
    wire        int_pin, chg_pin;
    wire [1:0]  lim;
    wire [2:0]  tsf;
    int         error_cnt = 0, num_checks = 0, cyc = 0;
    logic [31:0] rs = 32'h171749EA;
    always #4 clk = ~clk;
    csc_top #(.SAFETY_CYC(200), .WDOG_CYC(50)) u_dut (.CLK(clk), .NRST(nrst),
        .CHARGE_DISABLE_IN(dis), .SOURCE_SELECT_IN(psel), .PACK_TS_COLD(cold),
        .PACK_TS_HOT(hot), .PACK_TS_WARM(warm), .CHARGE_ACTIVE(ca), .OTHER_FAULT(flt),
        .HOST_ACCESS(hacc), .HOST_TMR_RST(hrst), .STAT_ENABLE(sten), .ACC_POWER_EN(acc),
        .HOST_ILIM(ilim), .INT_STAT_O(int_o), .INT_STAT_OE(int_oe), .CHG_STAT_O(chg_o),
        .CHG_STAT_OE(chg_oe), .ACCESSORY_POWER_OUT(accout), .CHARGE_RUN(run),
        .HIZ_MODE(hiz), .CHARGE_REDUCED(red), .INPUT_LIMIT(lim), .CHARGE_1A(c1a),
        .HOST_MODE(hmode), .SAFETY_EXPIRED(sexp), .TS_FAULT(tsf));
    csc_host_model u_host (.int_o(int_o), .int_oe(int_oe), .chg_o(chg_o), .chg_oe(chg_oe),
        .int_pin(int_pin), .chg_pin(chg_pin));
    function logic [31:0] nxt(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function logic [3:0] lim_exp(input logic p);
        // usb: 100 mA limit, no 1 A; adapter: no limit, 1 A charge
        return p ? 4'h1 : 4'h4;
    endfunction
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // cut a hang short well past the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc > 50000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        tk(12);
        chk({hmode, lim, run}, 4'b0010);
        nrst = 1'b1;
        repeat (400) begin
            rs = nxt(rs);
            {ca, dis, psel, hot, warm, cold, acc, sten, ilim, hrst} = rs[10:0];
            tk(1);
        end
        $display("random phase done");
        {ca, dis, hot, warm, cold, sten, hrst} = 7'b1100000;
        tk(5);
        chk({hiz, run, int_oe, chg_oe}, 4'b1000);
        tk(16010);
        {ca, dis, sten} = 3'b001;
        tk(5);
        chk({int_oe, chg_oe, int_pin, chg_pin}, 4'b0011);
        flt = 1'b1;
        tk(1);
        flt = 1'b0;
        tk(2);
        chk({int_oe, chg_oe, int_pin, chg_pin}, 4'b1100);
        tk(7997);
        flt = 1'b1;
        tk(1);
        flt = 1'b0;
        tk(8000);
        chk({int_oe, chg_oe, int_pin, chg_pin}, 4'b1100);
        tk(1);
        chk({int_oe, chg_oe, int_pin, chg_pin}, 4'b0011);
        $display("fault pulse test done");
        {ca, acc} = 2'b11;
        tk(4);
        chk({int_oe, chg_oe, int_pin, chg_pin}, 4'b1100);
        chk({3'b000, accout}, 4'h1);
        acc = 1'b0;
        dis = 1'b1;
        tk(5);
        chk({hiz, run, int_oe, accout}, 4'b1000);
        dis = 1'b0;
        tk(225);
        chk({2'b00, sexp, run}, 4'b0010);
        dis = 1'b1;
        tk(5);
        dis = 1'b0;
        tk(6);
        chk({2'b00, sexp, run}, 4'b0001);
        for (int i = 0; i < 2; i++) begin
            psel = i[0];
            tk(6);
            chk({1'b0, c1a, lim}, lim_exp(psel));
        end
        hot = 1'b1;
        tk(4);
        chk({run, tsf}, 4'b0010);
        {hot, warm} = 2'b01;
        tk(4);
        chk({red, tsf}, 4'b1001);
        $display("charge control test done");
        {warm, hacc, ilim} = 4'b0110;
        tk(1);
        {hot, hacc} = 2'b10;
        tk(4);
        chk({1'b0, hmode, run, tsf[1]}, 4'b0111);
        chk({2'b00, lim}, 4'h2);
        tk(60);
        chk({hmode, run, lim}, 4'b0001);
        $display("host mode test done");
        wrap_up();
    end
endmodule // test_charger_status_control
